// ---- lqm_pkg.sv ----
// Constants, field layouts and carrier types for the link quality monitor
package lqm_pkg;
    localparam int LQM_ADDR_W = 8;
    localparam int LQM_IDX_W = 6;
    // Register indices; byte address is four times the index
    localparam logic [5:0] LQM_IDX_VAR_CTRL = 6'h1a;
    localparam logic [5:0] LQM_IDX_VAR_DATA = 6'h1b;
    localparam logic [5:0] LQM_IDX_MON_CTRL = 6'h1d;
    localparam logic [5:0] LQM_IDX_THR_ACC = 6'h1e;
    // Variance control fields
    localparam int LQM_VC_RDY_BIT = 15;
    localparam int LQM_VC_FREEZE_BIT = 3;
    localparam int LQM_VC_TMR_LSB = 1;
    localparam int LQM_VC_EN_BIT = 0;
    // Monitor control fields
    localparam int LQM_MC_ON_BIT = 15;
    localparam int LQM_MC_RST_LSB = 10;
    localparam int LQM_NPARAM = 5;
    localparam int LQM_NWARN = 2 * LQM_NPARAM;
    // Threshold reset values sit at the extremes, so no parameter raises a warning until they are set
    localparam logic [7:0] LQM_THR_RESET_LO = 8'h00;
    localparam logic [7:0] LQM_THR_RESET_HI = 8'hff;
    localparam logic [15:0] LQM_VAR_DATA_RESET = 16'h0000;
    // Timing
    localparam int LQM_CLK_PERIOD_NS = 10;
    localparam int LQM_VAR_UNIT_NS = 1048576;
    localparam int LQM_VAR_UNIT_CYCLES = LQM_VAR_UNIT_NS / LQM_CLK_PERIOD_NS;
    localparam int LQM_VAR_UNITS_PER_STEP = 2;
    localparam int LQM_TMR_CNT_W = 24;
    localparam int LQM_TMR_UNIT_W = 4;

    typedef enum logic {
        LQM_VR_LOW = 1'b0,
        LQM_VR_HIGH = 1'b1
    } lqm_var_phase_t;

    // Adapted receiver parameters; equalizer in the low byte
    typedef struct packed {
        logic [7:0] freq_control;
        logic [7:0] freq_offset;
        logic [7:0] baseline_wander_param;
        logic [7:0] gain_control_param;
        logic [7:0] equalizer_coeff_param;
    } lqm_params_t;

    // Threshold access register layout, bits 13:0
    typedef struct packed {
        logic sample;
        logic write;
        logic [2:0] sel;
        logic hi;
        logic [7:0] data;
    } lqm_thr_cmd_t;
endpackage

// ---- lqm_var_timer.sv ----
// Variance computation period timer producing one-cycle elapse pulses
`timescale 1ns/1ps
module lqm_var_timer
    import lqm_pkg::*;
#(
    parameter int UNIT_CYCLES = LQM_VAR_UNIT_CYCLES
) (
    input wire logic pclk, // Clock
    input wire logic presetn, // Async reset, active low
    input wire logic restart, // Restart the period from zero
    input wire logic enable, // Computation enabled
    input wire logic [1:0] period_sel, // Period select, 2 ms steps
    output logic elapsed // One-cycle pulse at period end
);
    logic [LQM_TMR_CNT_W-1:0] cyc_cnt;
    logic [LQM_TMR_UNIT_W-1:0] unit_cnt;
    logic [LQM_TMR_UNIT_W-1:0] unit_last;
    logic unit_tick;

    assign unit_tick = (cyc_cnt == LQM_TMR_CNT_W'(UNIT_CYCLES - 1));
    assign unit_last = LQM_TMR_UNIT_W'((32'(period_sel) + 1) * LQM_VAR_UNITS_PER_STEP - 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_cnt <= '0;
        end else if (restart || !enable || unit_tick) begin
            cyc_cnt <= '0;
        end else begin
            cyc_cnt <= cyc_cnt + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unit_cnt <= '0;
            elapsed <= 1'b0;
        end else if (restart || !enable) begin
            unit_cnt <= '0;
            elapsed <= 1'b0;
        end else if (unit_tick) begin
            elapsed <= (unit_cnt >= unit_last);
            unit_cnt <= (unit_cnt >= unit_last) ? '0 : unit_cnt + 1'b1;
        end else begin
            elapsed <= 1'b0;
        end
    end
endmodule

// ---- lqm_monitor.sv ----
// Link quality monitor: variance readout, threshold monitor, APB registers
`timescale 1ns/1ps
module lqm_monitor
    import lqm_pkg::*;
#(
    parameter int VAR_UNIT_CYCLES = LQM_VAR_UNIT_CYCLES
) (
    input wire logic pclk, // Clock, 100 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction, 1 = write
    input wire logic [LQM_ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire logic [31:0] var_sum_in, // Running variance sum from receiver
    input wire lqm_params_t params, // Adapted receiver parameters
    input wire logic link_100_up, // Valid 100 Mb link
    input wire logic signal_detect_option, // Signal-detect option bit
    input wire logic lq_int_enable, // Link quality interrupt enabled in mask
    output logic lq_irq, // Interrupt request, level
    output logic dsp_restart, // Pulse: reset receiver DSP, restart adaptation
    output logic link_drop // Pulse: drop reported link status
);
    function automatic logic reg_hit(input logic [LQM_ADDR_W-1:0] a,
                                     input logic [LQM_IDX_W-1:0] idx);
        reg_hit = (a[LQM_ADDR_W-1:2] == idx) && (a[1:0] == 2'b00);
    endfunction

    // Bus strobes
    logic access;
    logic xfer;
    logic wr;
    logic rd;
    assign access = psel && penable && !pready;
    assign xfer = psel && penable && pready;
    assign wr = xfer && pwrite;
    assign rd = xfer && !pwrite;

    logic wr_var_ctrl;
    logic rd_var_data;
    logic wr_mon_ctrl;
    logic rd_mon_ctrl;
    logic wr_thr_acc;
    assign wr_var_ctrl = wr && reg_hit(paddr, LQM_IDX_VAR_CTRL);
    assign rd_var_data = rd && reg_hit(paddr, LQM_IDX_VAR_DATA);
    assign wr_mon_ctrl = wr && reg_hit(paddr, LQM_IDX_MON_CTRL);
    assign rd_mon_ctrl = rd && reg_hit(paddr, LQM_IDX_MON_CTRL);
    assign wr_thr_acc = wr && reg_hit(paddr, LQM_IDX_THR_ACC);

    // Variance state
    logic var_enable;
    logic var_freeze;
    logic var_ready;
    logic [1:0] var_period;
    logic [31:0] var_snap;
    lqm_var_phase_t var_phase;
    logic var_elapsed;

    // Monitor state
    logic mon_on;
    logic [LQM_NPARAM-1:0] restart_en;
    logic [LQM_NWARN-1:0] warn;
    logic [LQM_NWARN-1:0] warn_set;
    logic [LQM_NWARN-1:0] warn_clr;
    logic [LQM_NPARAM-1:0] restart_hit;
    logic irq_armed;
    logic mon_active;

    // Threshold access state
    logic [7:0] thr_lo [LQM_NPARAM];
    logic [7:0] thr_hi [LQM_NPARAM];
    logic acc_sample;
    logic [2:0] acc_sel;
    logic acc_hi;
    logic [7:0] sampled;
    logic [LQM_NPARAM-1:0][7:0] pvec;
    lqm_thr_cmd_t cmd;

    assign pvec = params;
    assign cmd = lqm_thr_cmd_t'(pwdata[13:0]);

    lqm_var_timer #(
        .UNIT_CYCLES(VAR_UNIT_CYCLES)
    ) u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .restart(wr_var_ctrl),
        .enable(var_enable),
        .period_sel(var_period),
        .elapsed(var_elapsed)
    );

    // APB answer: one wait state, data and error registered with pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= access;
        end
    end

    logic [31:0] rd_mux;
    logic mapped;
    always_comb begin
        rd_mux = '0;
        mapped = 1'b1;
        if (reg_hit(paddr, LQM_IDX_VAR_CTRL)) begin
            rd_mux[LQM_VC_RDY_BIT] = var_ready;
            rd_mux[LQM_VC_FREEZE_BIT] = var_freeze;
            rd_mux[LQM_VC_TMR_LSB +: 2] = var_period;
            rd_mux[LQM_VC_EN_BIT] = var_enable;
        end else if (reg_hit(paddr, LQM_IDX_VAR_DATA)) begin
            rd_mux[15:0] = (var_phase == LQM_VR_LOW) ? var_snap[15:0] : var_snap[31:16];
        end else if (reg_hit(paddr, LQM_IDX_MON_CTRL)) begin
            rd_mux[LQM_MC_ON_BIT] = mon_on;
            rd_mux[LQM_MC_RST_LSB +: LQM_NPARAM] = restart_en;
            rd_mux[LQM_NWARN-1:0] = warn;
        end else if (reg_hit(paddr, LQM_IDX_THR_ACC)) begin
            rd_mux[13] = acc_sample;
            rd_mux[11:9] = acc_sel;
            rd_mux[8] = acc_hi;
            if (acc_sample) begin
                rd_mux[7:0] = sampled;
            end else if (acc_sel < 3'(LQM_NPARAM)) begin
                rd_mux[7:0] = acc_hi ? thr_hi[acc_sel] : thr_lo[acc_sel];
            end
        end else begin
            mapped = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pslverr <= 1'b0;
        end else if (access) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= !mapped;
        end
    end

    // Variance control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            var_enable <= 1'b0;
            var_period <= 2'b00;
        end else if (wr_var_ctrl) begin
            var_enable <= pwdata[LQM_VC_EN_BIT];
            var_period <= pwdata[LQM_VC_TMR_LSB +: 2];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            var_freeze <= 1'b0;
        end else if (wr_var_ctrl) begin
            var_freeze <= pwdata[LQM_VC_FREEZE_BIT];
        end else if (rd_var_data && var_phase == LQM_VR_HIGH) begin
            var_freeze <= 1'b0;
        end
    end

    // Read phase: setting the hold restarts at the low half
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            var_phase <= LQM_VR_LOW;
        end else if (wr_var_ctrl && pwdata[LQM_VC_FREEZE_BIT]) begin
            var_phase <= LQM_VR_LOW;
        end else if (rd_var_data) begin
            var_phase <= (var_phase == LQM_VR_LOW) ? LQM_VR_HIGH : LQM_VR_LOW;
        end
    end

    // Snapshot loads only at period end and never while held
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            var_snap <= {LQM_VAR_DATA_RESET, LQM_VAR_DATA_RESET};
        end else if (var_elapsed && var_enable && !var_freeze) begin
            var_snap <= var_sum_in;
        end
    end

    // Ready: a new load wins over the clear by the second read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            var_ready <= 1'b0;
        end else if (var_elapsed && var_enable && !var_freeze) begin
            var_ready <= 1'b1;
        end else if (rd_var_data && var_phase == LQM_VR_HIGH) begin
            var_ready <= 1'b0;
        end
    end

    // Monitor control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mon_on <= 1'b0;
            restart_en <= '0;
        end else if (wr_mon_ctrl) begin
            mon_on <= pwdata[LQM_MC_ON_BIT];
            restart_en <= pwdata[LQM_MC_RST_LSB +: LQM_NPARAM];
        end
    end

    assign mon_active = mon_on && link_100_up;

    // Per-parameter comparison; strict compares keep extremes silent
    genvar gi;
    generate
        for (gi = 0; gi < LQM_NPARAM; gi++) begin : g_par
            assign warn_set[2*gi+1] = mon_active && (pvec[gi] > thr_hi[gi]);
            assign warn_set[2*gi] = mon_active && (pvec[gi] < thr_lo[gi]);
            assign restart_hit[gi] = restart_en[gi]
                && (warn_set[2*gi+1] || warn_set[2*gi])
                && !(warn[2*gi+1] || warn[2*gi]);
        end
    endgenerate

    // Clear only what the read reported, so a later event is kept
    assign warn_clr = rd_mon_ctrl ? prdata[LQM_NWARN-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            warn <= '0;
        end else begin
            warn <= (warn & ~warn_clr) | warn_set;
        end
    end

    // Interrupt request fires once per arming; control read re-arms
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lq_irq <= 1'b0;
            irq_armed <= 1'b1;
        end else if ((|warn_set) && lq_int_enable && (irq_armed || rd_mon_ctrl)) begin
            lq_irq <= 1'b1;
            irq_armed <= 1'b0;
        end else if (rd_mon_ctrl) begin
            lq_irq <= 1'b0;
            irq_armed <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dsp_restart <= 1'b0;
            link_drop <= 1'b0;
        end else begin
            dsp_restart <= |restart_hit;
            link_drop <= (|restart_hit) && !signal_detect_option;
        end
    end

    // Threshold access register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_sample <= 1'b0;
            acc_sel <= 3'b000;
            acc_hi <= 1'b0;
        end else if (wr_thr_acc) begin
            acc_sample <= cmd.sample;
            acc_sel <= cmd.sel;
            acc_hi <= cmd.hi;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sampled <= 8'h00;
        end else if (wr_thr_acc && cmd.sample && cmd.sel < 3'(LQM_NPARAM)) begin
            sampled <= pvec[cmd.sel];
        end
    end

    generate
        for (gi = 0; gi < LQM_NPARAM; gi++) begin : g_thr
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    thr_lo[gi] <= LQM_THR_RESET_LO;
                    thr_hi[gi] <= LQM_THR_RESET_HI;
                end else if (wr_thr_acc && cmd.write && cmd.sel == 3'(gi)) begin
                    if (cmd.hi) begin
                        thr_hi[gi] <= cmd.data;
                    end else begin
                        thr_lo[gi] <= cmd.data;
                    end
                end
            end
        end
    endgenerate
endmodule

// ---- lqm_monitor_assertions.sv ----
// Port-level checker for the link quality monitor, bound into lqm_monitor
`timescale 1ns/1ps
module lqm_checker
    import lqm_pkg::*;
#(
    parameter int VAR_UNIT_CYCLES = LQM_VAR_UNIT_CYCLES
) (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [LQM_ADDR_W-1:0] paddr, // APB address
    input wire logic [31:0] prdata, // APB read data
    input wire logic pready, // APB ready
    input wire logic pslverr, // APB error
    input wire logic link_100_up, // 100 Mb link
    input wire logic signal_detect_option, // Signal-detect option
    input wire logic lq_int_enable, // Interrupt enabled
    input wire logic lq_irq, // Interrupt request
    input wire logic dsp_restart, // Adaptation restart
    input wire logic link_drop // Link drop
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic mc_read;
    assign mc_read = psel && penable && pready && !pwrite && paddr == {LQM_IDX_MON_CTRL, 2'b00};
    a_irq_needs_mask: assert property ($rose(lq_irq) |-> $past(lq_int_enable))
        else $error("interrupt rose while masked");
    a_irq_held: assert property (lq_irq && !mc_read |=> lq_irq)
        else $error("interrupt dropped without a control read");
    a_restart_link: assert property (dsp_restart |-> $past(link_100_up))
        else $error("restart without a 100 Mb link");
    a_drop_paired: assert property (link_drop |-> dsp_restart)
        else $error("link drop without restart");
    a_drop_option: assert property (dsp_restart |-> link_drop == !$past(signal_detect_option))
        else $error("link drop does not follow the option bit");
    a_read_width: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
        else $error("upper read data not zero");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_one_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
        else $error("ready not after one wait state");
    a_bad_addr: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
        else $error("misaligned access not refused");
    c_irq: cover property ($rose(lq_irq));
    c_drop: cover property (dsp_restart && link_drop);
    c_restart_only: cover property (dsp_restart && !link_drop);
    c_warn_read: cover property (mc_read && prdata[9:0] != 10'h000);
endmodule

bind lqm_monitor lqm_checker #(.VAR_UNIT_CYCLES(VAR_UNIT_CYCLES)) u_lqm_checker (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
    .link_100_up, .signal_detect_option, .lq_int_enable, .lq_irq, .dsp_restart, .link_drop);

// ---- lqm_rx_model.sv ----
// Receiver-side model: adapted parameters, variance sum and link status
`timescale 1ns/1ps
module lqm_rx_model
    import lqm_pkg::*;
#(
    parameter int SETTLE = 12
) (
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire lqm_params_t target, // Values adaptation settles to
    input wire logic [31:0] sum_set, // Variance sum to present
    input wire logic link_req, // Cable offers a 100 Mb link
    input wire logic dsp_restart, // Restart from the monitor
    input wire logic link_drop, // Link drop from the monitor
    output lqm_params_t params, // Adapted parameters
    output logic [31:0] var_sum_in, // Running variance sum
    output logic link_100_up // Reported link
);
    int hold;
    logic dropped;
    // A restart sends adaptation back to mid scale; after a link drop the link stays down meanwhile
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold <= 0;
            dropped <= 1'b0;
        end else begin
            hold <= dsp_restart ? SETTLE : (hold > 0 ? hold - 1 : 0);
            dropped <= link_drop || (dropped && hold > 1);
        end
    end
    assign params = (hold > 0) ? lqm_params_t'({5{8'h80}}) : target;
    assign link_100_up = link_req && !dropped;
    assign var_sum_in = sum_set;
endmodule

// ---- test_link_quality_monitor.sv ----
// Self-checking bench for the link quality monitor
`timescale 1ns/1ps
module test_link_quality_monitor;
    import lqm_pkg::*;
    localparam int SETTLE = 12;
    localparam logic [7:0] A_VC = {LQM_IDX_VAR_CTRL, 2'b00};
    localparam logic [7:0] A_VD = {LQM_IDX_VAR_DATA, 2'b00};
    localparam logic [7:0] A_MC = {LQM_IDX_MON_CTRL, 2'b00};
    localparam logic [7:0] A_TA = {LQM_IDX_THR_ACC, 2'b00};
    localparam lqm_params_t MID = lqm_params_t'({5{8'h80}});
    typedef struct packed {
        logic [2:0] sel;
        logic hi;
        logic [15:0] flag;
    } lqm_row_t;
    // Parameter, high or low side, and the warning it must raise
    lqm_row_t rows[10] = '{
        '{3'd0, 1'b0, 16'h0001}, '{3'd0, 1'b1, 16'h0002}, '{3'd1, 1'b0, 16'h0004},
        '{3'd1, 1'b1, 16'h0008}, '{3'd2, 1'b0, 16'h0010}, '{3'd2, 1'b1, 16'h0020},
        '{3'd3, 1'b0, 16'h0040}, '{3'd3, 1'b1, 16'h0080}, '{3'd4, 1'b0, 16'h0100},
        '{3'd4, 1'b1, 16'h0200}};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, link_100_up;
    logic link_req, signal_detect_option, lq_int_enable, lq_irq, dsp_restart, link_drop;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, sum_set, var_sum_in, base;
    lqm_params_t target, params;
    lqm_row_t r;
    int fail_count = 0;
    int checks_done = 0;
    int cycles = 0;
    int restarts = 0;
    int drops = 0;
    int n, m;
    lqm_monitor #(.VAR_UNIT_CYCLES(10)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .var_sum_in, .params, .link_100_up,
        .signal_detect_option, .lq_int_enable, .lq_irq, .dsp_restart, .link_drop);
    lqm_rx_model #(.SETTLE(SETTLE)) u_rx (.pclk, .presetn, .target, .sum_set, .link_req,
        .dsp_restart, .link_drop, .params, .var_sum_in, .link_100_up);
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        restarts <= restarts + int'(dsp_restart);
        drops <= drops + int'(link_drop);
        if (cycles == 4000) begin
            fail_count++;
            end_sim();
        end
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Ready is looked at mid-cycle; the transfer completes at the next rising edge
        do begin
            @(negedge pclk);
        end while (pready !== 1'b1);
        @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic end_sim;
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {link_req, signal_detect_option, lq_int_enable} = 3'b111;
        sum_set = 32'h1234_5678;
        target = MID;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, A_MC, 32'h0000_0000);
        chk("control reset", rd, 32'h0000_0000);
        apb(1'b0, A_VD, 32'h0000_0000);
        chk("variance reset", rd, 32'h0000_0000);
        $display("reset test done");
        for (int i = 0; i < 10; i++) begin
            r = rows[i];
            base = 32'h0000_8000 | (32'h0000_0001 << (10 + r.sel));
            signal_detect_option <= r.hi;
            apb(1'b1, A_TA, {19'h0_0000, 1'b1, r.sel, r.hi, r.hi ? 8'hfe : 8'h01});
            apb(1'b1, A_MC, base);
            n = restarts;
            m = drops;
            target[8 * r.sel +: 8] <= r.hi ? 8'hff : 8'h00;
            repeat (4) @(posedge pclk);
            chk("irq set", lq_irq, 32'h0000_0001);
            target <= MID;
            repeat (SETTLE + 4) @(posedge pclk);
            chk("restarts", 32'(restarts - n), 32'h0000_0001);
            chk("drops", 32'(drops - m), {31'h0, ~r.hi});
            apb(1'b0, A_MC, 32'h0000_0000);
            chk("warnings", rd, base | r.flag);
            apb(1'b0, A_MC, 32'h0000_0000);
            chk("after read", rd, base);
            @(negedge pclk);
            chk("irq cleared", lq_irq, 32'h0000_0000);
            apb(1'b1, A_TA, {19'h0_0000, 1'b1, r.sel, r.hi, {8{r.hi}}});
        end
        $display("threshold table done");
        apb(1'b1, A_MC, 32'h0000_8000);
        target <= lqm_params_t'({5{8'hff}});
        repeat (4) @(posedge pclk);
        target <= '0;
        repeat (4) @(posedge pclk);
        target <= MID;
        apb(1'b0, A_MC, 32'h0000_0000);
        chk("extremes", rd, 32'h0000_8000);
        chk("no irq", lq_irq, 32'h0000_0000);
        apb(1'b1, A_TA, {19'h0_0000, 1'b1, 3'd0, 1'b1, 8'h10});
        link_req <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(1'b0, A_MC, 32'h0000_0000);
        chk("link down", rd, 32'h0000_8000);
        apb(1'b1, A_MC, 32'h0000_0000);
        link_req <= 1'b1;
        lq_int_enable <= 1'b0;
        repeat (4) @(posedge pclk);
        apb(1'b0, A_MC, 32'h0000_0000);
        chk("monitor off", rd, 32'h0000_0000);
        apb(1'b1, A_MC, 32'h0000_8000);
        repeat (4) @(posedge pclk);
        chk("masked irq", lq_irq, 32'h0000_0000);
        apb(1'b0, A_MC, 32'h0000_0000);
        chk("masked warn", rd, 32'h0000_8002);
        apb(1'b1, A_TA, {19'h0_0000, 1'b1, 3'd0, 1'b1, 8'hff});
        lq_int_enable <= 1'b1;
        $display("monitor gating done");
        apb(1'b1, A_VC, 32'h0000_0001);
        n = 0;
        do begin
            apb(1'b0, A_VC, 32'h0000_0000);
            n++;
        end while (rd[15] !== 1'b1 && n < 20);
        chk("ready", rd[15], 32'h0000_0001);
        apb(1'b1, A_VC, 32'h0000_000f);
        sum_set <= 32'h9abc_def0;
        repeat (100) @(posedge pclk);
        apb(1'b0, A_VD, 32'h0000_0000);
        chk("low half", rd, 32'h0000_5678);
        apb(1'b0, A_VD, 32'h0000_0000);
        chk("high half", rd, 32'h0000_1234);
        apb(1'b0, A_VC, 32'h0000_0000);
        chk("hold cleared", rd, 32'h0000_0007);
        repeat (30) @(posedge pclk);
        apb(1'b0, A_VC, 32'h0000_0000);
        chk("period early", rd, 32'h0000_0007);
        repeat (20) @(posedge pclk);
        apb(1'b0, A_VC, 32'h0000_0000);
        chk("period end", rd, 32'h0000_8007);
        apb(1'b0, A_VD, 32'h0000_0000);
        chk("new load", rd, 32'h0000_def0);
        $display("variance test done");
        apb(1'b0, 8'h00, 32'h0000_0000);
        chk("unmapped", er, 32'h0000_0001);
        apb(1'b1, A_MC + 8'h01, 32'h0000_ffff);
        chk("misaligned", er, 32'h0000_0001);
        apb(1'b1, A_MC, 32'h0000_fc00);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, A_MC, 32'h0000_0000);
        chk("second reset", rd, 32'h0000_0000);
        $display("error and reset tests done");
        end_sim();
    end
endmodule
